// *** hw/adc_sequencer_control.sv ***
// Converter control block with Wishbone registers and interrupt
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module adc_sequencer_control
   import adc_seq_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
)(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       cyc_i,
   input  wire logic       stb_i,
   input  wire logic       we_i,
   input  wire logic [7:0] adr_i,
   input  wire logic [7:0] dat_i,
   input  wire logic       sel_i,
   output logic      [7:0] dat_o,
   output logic            ack_o,
   output logic            irq_o,
   input  wire logic       sleep_i,
   input  wire logic       rc_clk_i,
   input  wire logic       comp_i,
   output logic      [7:0] dac_code_o,
   output logic      [2:0] channel_o,
   output logic            sample_o,
   output logic            ext_ref_o,
   output logic      [7:0] analog_pins_o,
   output logic            power_o
);
   sar_if sar();

   logic [7:0] control_ff;
   logic [2:0] port_cfg_ff;
   logic       irq_status_ff;
   logic       irq_mask_ff;
   logic [7:0] dat_ff;
   logic       ack_ff;
   logic       irq_ff;
   logic [7:0] dac_ff;
   logic [2:0] chan_ff;
   logic       sample_ff;
   logic       ref_ff;
   logic [7:0] pins_ff;
   logic       power_ff;
   logic [4:0] div_cnt_ff;
   logic       div_clk_ff;
   logic       tick_ff;
   logic       rc_s1_ff;
   logic       rc_s2_ff;
   logic       rc_s3_ff;
   logic       comp_s1_ff;
   logic       comp_s2_ff;
   logic       sleep_s1_ff;
   logic       sleep_s2_ff;
   logic       nxt_tick;
   logic [4:0] half_lim;
   logic       wr_stb;
   logic       rd_stb;
   logic       go_write;
   logic       start_req;
   logic       halt;

   // Legal channel clamp for the smaller variant
   function automatic logic [2:0] clamp_channel(input logic [2:0] ch);
      if (!LARGE_VARIANT && ch > CHANNEL_MAX_SMALL) begin
         return CHANNEL_MAX_SMALL;
      end
      return ch;
   endfunction : clamp_channel

   // Analog pin map per port configuration code
   function automatic logic [7:0] analog_map(input logic [2:0] cfg);
      logic [7:0] m;
      m = 8'h00;
      case (cfg)
         3'h0:    m = 8'hFF;
         3'h1:    m = 8'hF7;
         3'h2:    m = 8'h1F;
         3'h3:    m = 8'h17;
         3'h4:    m = 8'h0B;
         3'h5:    m = 8'h03;
         default: m = 8'h00;
      endcase
      if (!LARGE_VARIANT) begin
         m = m & 8'h1F;
      end
      return m;
   endfunction : analog_map

   assign wr_stb    = cyc_i && stb_i && we_i && sel_i && !ack_ff;
   assign rd_stb    = cyc_i && stb_i && !we_i && !ack_ff;
   assign go_write  = wr_stb && adr_i == OFS_CONTROL;
   // Done cycle excluded so a finished conversion cannot restart before go clears
   assign start_req = control_ff[BIT_GO] && control_ff[BIT_POWER] && !sar.busy && !sar.done;
   // Sleep stops any conversion not clocked from RC
   assign halt      = sleep_s2_ff && control_ff[POS_CLKSEL +: 2] != CLK_RC;

   // Synchronisers for pin inputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rc_s1_ff    <= 1'b0;
         rc_s2_ff    <= 1'b0;
         rc_s3_ff    <= 1'b0;
         comp_s1_ff  <= 1'b0;
         comp_s2_ff  <= 1'b0;
         sleep_s1_ff <= 1'b0;
         sleep_s2_ff <= 1'b0;
      end else begin
         rc_s1_ff    <= rc_clk_i;
         rc_s2_ff    <= rc_s1_ff;
         rc_s3_ff    <= rc_s2_ff;
         comp_s1_ff  <= comp_i;
         comp_s2_ff  <= comp_s1_ff;
         sleep_s1_ff <= sleep_i;
         sleep_s2_ff <= sleep_s1_ff;
      end
   end

   // Conversion clock source selection
   always_comb begin
      half_lim = DIV2_HALF;
      case (control_ff[POS_CLKSEL +: 2])
         CLK_DIV2:  half_lim = DIV2_HALF;
         CLK_DIV8:  half_lim = DIV8_HALF;
         CLK_DIV32: half_lim = DIV32_HALF;
         default:   half_lim = DIV2_HALF;
      endcase
      if (control_ff[POS_CLKSEL +: 2] == CLK_RC) begin
         nxt_tick = rc_s2_ff && !rc_s3_ff;
      end else begin
         nxt_tick = div_clk_ff && div_cnt_ff == half_lim;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !sar.busy) begin
         div_cnt_ff <= 5'h00;
         div_clk_ff <= 1'b0;
         tick_ff    <= 1'b0;
      end else begin
         tick_ff <= nxt_tick;
         if (div_cnt_ff == half_lim) begin
            div_cnt_ff <= 5'h00;
            div_clk_ff <= !div_clk_ff;
         end else begin
            div_cnt_ff <= div_cnt_ff + 5'h01;
         end
      end
   end

   assign sar.tick  = tick_ff;
   assign sar.start = start_req && !halt;
   assign sar.comp  = comp_s2_ff;
   // Clearing go or power, or a non-RC sleep, aborts
   assign sar.abort = sar.busy && (!control_ff[BIT_GO] || !control_ff[BIT_POWER] || halt);

   sar_core u_core (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .sar   (sar)
   );

   // Main control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_ff <= CONTROL_RESET;
      end else if (go_write) begin
         control_ff <= dat_i & CONTROL_WMASK;
         control_ff[POS_CHANNEL +: 3] <= clamp_channel(dat_i[POS_CHANNEL +: 3]);
         if (!dat_i[BIT_POWER]) begin
            control_ff[BIT_GO] <= 1'b0;
         end
      end else if (sar.done) begin
         control_ff[BIT_GO] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_cfg_ff <= PORT_CFG_RESET;
      end else if (wr_stb && adr_i == OFS_PORT_CFG) begin
         port_cfg_ff <= dat_i[2:0];
      end
   end

   // Done flag: hardware set wins over write-one-to-clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_ff <= 1'b0;
      end else if (sar.done) begin
         irq_status_ff <= 1'b1;
      end else if (wr_stb && adr_i == OFS_IRQ_STATUS && dat_i[0]) begin
         irq_status_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_ff <= 1'b0;
      end else if (wr_stb && adr_i == OFS_IRQ_MASK) begin
         irq_mask_ff <= dat_i[0];
      end
   end

   // Bus answer one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 8'h00;
      end else begin
         ack_ff <= cyc_i && stb_i && !ack_ff;
         if (rd_stb) begin
            case (adr_i)
               OFS_CONTROL:    dat_ff <= control_ff;
               OFS_RESULT:     dat_ff <= sar.result;
               OFS_PORT_CFG:   dat_ff <= {5'h00, port_cfg_ff};
               OFS_IRQ_STATUS: dat_ff <= {7'h00, irq_status_ff};
               OFS_IRQ_MASK:   dat_ff <= {7'h00, irq_mask_ff};
               OFS_MISC:       dat_ff <= {6'h00, sar.busy, LARGE_VARIANT};
               default:        dat_ff <= 8'h00;
            endcase
         end
      end
   end

   // Analog side outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_ff    <= 1'b0;
         dac_ff    <= 8'h00;
         chan_ff   <= 3'h0;
         sample_ff <= 1'b0;
         ref_ff    <= 1'b0;
         pins_ff   <= 8'hFF;
         power_ff  <= 1'b0;
      end else begin
         irq_ff    <= irq_status_ff && irq_mask_ff;
         dac_ff    <= sar.trial;
         chan_ff   <= control_ff[POS_CHANNEL +: 3];
         sample_ff <= control_ff[BIT_POWER] && !halt && !sar.busy;
         ref_ff    <= port_cfg_ff == PCFG_EXT_REF_A || port_cfg_ff == PCFG_EXT_REF_B ||
                      port_cfg_ff == PCFG_EXT_REF_C;
         pins_ff   <= analog_map(port_cfg_ff);
         power_ff  <= control_ff[BIT_POWER] && !halt;
      end
   end

   assign dat_o         = dat_ff;
   assign ack_o         = ack_ff;
   assign irq_o         = irq_ff;
   assign dac_code_o    = dac_ff;
   assign channel_o     = chan_ff;
   assign sample_o      = sample_ff;
   assign ext_ref_o     = ref_ff;
   assign analog_pins_o = pins_ff;
   assign power_o       = power_ff;
endmodule : adc_sequencer_control

// *** hw/adc_seq_pkg.sv ***
// Package with register map, field layout and timing constants
package adc_seq_pkg;
   localparam logic [7:0] OFS_CONTROL      = 8'h1F;
   localparam logic [7:0] OFS_RESULT       = 8'h1E;
   localparam logic [7:0] OFS_PORT_CFG     = 8'h9F;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h21;
   localparam logic [7:0] OFS_MISC         = 8'h22;
   localparam int         BIT_POWER        = 0;
   localparam int         BIT_GO           = 2;
   localparam int         POS_CHANNEL      = 3;
   localparam int         POS_CLKSEL       = 6;
   localparam logic [7:0] CONTROL_WMASK    = 8'hFD;
   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam logic [2:0] PORT_CFG_RESET   = 3'h0;
   localparam logic [1:0] CLK_DIV2         = 2'h0;
   localparam logic [1:0] CLK_DIV8         = 2'h1;
   localparam logic [1:0] CLK_DIV32        = 2'h2;
   localparam logic [1:0] CLK_RC           = 2'h3;
   localparam logic [4:0] DIV2_HALF        = 5'h00;
   localparam logic [4:0] DIV8_HALF        = 5'h03;
   localparam logic [4:0] DIV32_HALF       = 5'h0F;
   localparam int         RESULT_BITS      = 8;
   localparam logic [3:0] CONV_PERIODS     = 4'h9;
   localparam logic [2:0] CHANNEL_MAX_SMALL = 3'h4;
   localparam logic [2:0] CHANNEL_MAX_LARGE = 3'h7;
   localparam logic [2:0] PCFG_EXT_REF_A   = 3'h1;
   localparam logic [2:0] PCFG_EXT_REF_B   = 3'h3;
   localparam logic [2:0] PCFG_EXT_REF_C   = 3'h5;
endpackage : adc_seq_pkg

// *** hw/sar_if.sv ***
// Interface between control logic and successive-approximation core
`timescale 1ns/1ps
interface sar_if;
   logic       tick;
   logic       start;
   logic       abort;
   logic       busy;
   logic       done;
   logic [7:0] result;
   logic [7:0] trial;
   logic       comp;
   modport ctrl (output tick, output start, output abort, output comp,
                 input busy, input done, input result, input trial);
   modport core (input tick, input start, input abort, input comp,
                 output busy, output done, output result, output trial);
endinterface : sar_if

// *** hw/sar_core.sv ***
// Successive-approximation bit sequencer
`timescale 1ns/1ps
module sar_core
   import adc_seq_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   sar_if.core       sar
);
   logic [3:0] period_ff;
   logic [7:0] bits_ff;
   logic [7:0] pos_ff;
   logic       busy_ff;
   logic       done_ff;
   logic [7:0] result_ff;

   assign sar.busy   = busy_ff;
   assign sar.done   = done_ff;
   assign sar.result = result_ff;
   assign sar.trial  = bits_ff | pos_ff;

   // Nine periods: one sample then eight bit decisions
   always_ff @(posedge clk_i) begin
      done_ff <= 1'b0;
      if (rst_i || sar.abort) begin
         busy_ff   <= 1'b0;
         period_ff <= 4'h0;
         bits_ff   <= 8'h00;
         pos_ff    <= 8'h80;
      end else if (sar.start && !busy_ff) begin
         busy_ff   <= 1'b1;
         period_ff <= 4'h0;
         bits_ff   <= 8'h00;
         pos_ff    <= 8'h80;
      end else if (busy_ff && sar.tick) begin
         period_ff <= period_ff + 4'h1;
         if (period_ff != 4'h0) begin
            if (sar.comp) begin
               bits_ff <= bits_ff | pos_ff;
            end
            pos_ff <= pos_ff >> 1;
         end
         if (period_ff == CONV_PERIODS - 4'h1) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_ff <= 8'h00;
      end else if (busy_ff && sar.tick && period_ff == CONV_PERIODS - 4'h1) begin
         result_ff <= sar.comp ? (bits_ff | pos_ff) : bits_ff;
      end
   end
endmodule : sar_core

// *** tb/comp_model.sv ***
// Comparator model facing the converter trial code
`timescale 1ns/1ps
module comp_model (
   input  wire logic [7:0] vin_i,
   input  wire logic [7:0] dac_code_i,
   output logic            comp_o
);
   // Keep the bit while the input is at or above the trial code
   assign comp_o = (vin_i >= dac_code_i);
endmodule : comp_model

// *** tb/adc_seq_asserts.sv ***
// Port checker for the converter control block
`timescale 1ns/1ps
module adc_seq_asserts
   import adc_seq_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
)(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       we_i,
   input wire logic [7:0] adr_i,
   input wire logic [7:0] dat_i,
   input wire logic       sel_i,
   input wire logic [7:0] dat_o,
   input wire logic       ack_o,
   input wire logic       irq_o,
   input wire logic       power_o,
   input wire logic       sample_o,
   input wire logic [2:0] channel_o,
   input wire logic       ext_ref_o,
   input wire logic [7:0] analog_pins_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   bit1_zero_a: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i == OFS_CONTROL
      |=> !dat_o[1]) else $error("unused control bit read as one");
   off_idle_a: assert property (!power_o |-> !sample_o)
      else $error("sampler tracking while off");
   chan_range_a: assert property (cyc_i && stb_i && we_i && sel_i && !ack_o
      && adr_i == OFS_CONTROL |-> ##2 channel_o == ((!LARGE_VARIANT
      && $past(dat_i[POS_CHANNEL +: 3], 2) > CHANNEL_MAX_SMALL) ? CHANNEL_MAX_SMALL
      : $past(dat_i[POS_CHANNEL +: 3], 2))) else $error("channel field not routed");
   ref_pin_a: assert property (ext_ref_o |-> !analog_pins_o[3])
      else $error("reference pin still analog input");
   reset_vals_a: assert property ($past(rst_i) |-> !power_o && !irq_o && analog_pins_o == 8'hFF)
      else $error("outputs wrong after reset");
   dat_hold_a: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
      else $error("read data changed while idle");
endmodule : adc_seq_asserts
bind adc_sequencer_control adc_seq_asserts #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .dat_i(dat_i), .sel_i(sel_i),
   .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .power_o(power_o), .sample_o(sample_o),
   .channel_o(channel_o), .ext_ref_o(ext_ref_o), .analog_pins_o(analog_pins_o));

// *** tb/adc_sequencer_control_tb_top.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_sequencer_control_tb_top;
   import adc_seq_pkg::*;
   typedef struct {logic [7:0] adr; logic [7:0] wd; logic [7:0] rd;} row_t;
   logic       clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sleep_i = 0, rc_clk_i = 0;
   logic       sel_i = 0;
   logic [7:0] adr_i = 0, dat_i = 0, vin = 0, rd;
   wire logic [7:0] dat_o, dac_code_o, analog_pins_o;
   wire logic       ack_o, irq_o, comp, sample_o, ext_ref_o, power_o;
   wire logic [2:0] channel_o;
   int         err_count = 0, checks = 0;
   row_t rows[6] = '{'{8'h1F, 8'hC1, 8'hC1}, '{8'h1F, 8'h3B, 8'h39}, '{8'h1F, 8'h04, 8'h00},
                     '{8'h9F, 8'hFF, 8'h07}, '{8'h1E, 8'hFF, 8'h00}, '{8'h50, 8'h5A, 8'h00}};
   always #20 clk_i = ~clk_i;
   always #170 rc_clk_i = ~rc_clk_i;
   comp_model PM (.vin_i(vin), .dac_code_i(dac_code_o), .comp_o(comp));
   adc_sequencer_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_o(irq_o), .sleep_i(sleep_i), .rc_clk_i(rc_clk_i), .comp_i(comp),
      .dac_code_o(dac_code_o), .channel_o(channel_o), .sample_o(sample_o),
      .ext_ref_o(ext_ref_o), .analog_pins_o(analog_pins_o), .power_o(power_o));
   task automatic test_done;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      sel_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      sel_i <= 1'b0;
   endtask : wb
   task automatic no_done(input logic [7:0] v);
      wb(1'b0, OFS_RESULT, 8'h00);
      chk(rd, v);
      wb(1'b0, OFS_IRQ_STATUS, 8'h00);
      chk(rd, 8'h00);
   endtask : no_done
   task automatic conv(input logic [1:0] cs, input logic [7:0] v);
      int n, sp, t;
      n = 0;
      sp = (cs == CLK_RC) ? 0 : 2 << (2 * cs);
      vin <= v;
      sleep_i <= (cs == CLK_RC);
      wb(1'b1, OFS_CONTROL, {cs, 1'b0, cs, 3'h1});
      wb(1'b1, OFS_CONTROL, {cs, 1'b0, cs, 3'h5});
      t = $time / 40;
      do begin
         wb(1'b0, OFS_CONTROL, 8'h00);
         n++;
      end while (rd[BIT_GO] !== 1'b0 && n < 300);
      t = $time / 40 - t;
      chk({7'h0, rd[BIT_GO]}, 8'h00);
      if (sp > 0) chk({7'h0, t >= 8 * sp && t <= 9 * sp + 16}, 8'h01);
      wb(1'b0, OFS_RESULT, 8'h00);
      chk(rd, v);
      chk({7'h0, irq_o}, 8'h01);
      wb(1'b1, OFS_IRQ_STATUS, 8'h01);
      @(posedge clk_i);
      chk({7'h0, irq_o}, 8'h00);
   endtask : conv
   initial begin
      #(40 * 20000);
      err_count++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(analog_pins_o, 8'hFF);
      foreach (rows[i]) begin
         wb(1'b1, rows[i].adr, rows[i].wd);
         wb(1'b0, rows[i].adr, 8'h00);
         chk(rd, rows[i].rd);
      end
      wb(1'b1, OFS_PORT_CFG, 8'h01);
      @(posedge clk_i);
      chk({7'h0, ext_ref_o}, 8'h01);
      chk(analog_pins_o, 8'hF7);
      wb(1'b1, OFS_IRQ_MASK, 8'h01);
      conv(CLK_DIV2, 8'hFF);
      conv(CLK_DIV8, 8'h00);
      conv(CLK_DIV32, 8'h80);
      conv(CLK_RC, 8'h5A);
      sleep_i <= 1'b0;
      vin <= 8'h33;
      wb(1'b1, OFS_CONTROL, 8'h85);
      repeat (40) @(posedge clk_i);
      wb(1'b1, OFS_CONTROL, 8'h81);
      repeat (400) @(posedge clk_i);
      no_done(8'h5A);
      chk({7'h0, irq_o}, 8'h00);
      sleep_i <= 1'b1;
      wb(1'b1, OFS_CONTROL, 8'h45);
      repeat (300) @(posedge clk_i);
      chk({7'h0, power_o}, 8'h00);
      no_done(8'h5A);
      test_done();
   end
endmodule : adc_sequencer_control_tb_top
